// [common/psc_map.vh]
// register map, field positions and reset values of the sequence checker
`ifndef PSC_MAP_VH
`define PSC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PSC_ADDR_W          9
`define PSC_ADDR_CTRL       9'h14B
`define PSC_ADDR_REAL_CNT   9'h14C
`define PSC_ADDR_IMAG_CNT   9'h14D
`define PSC_ADDR_IRQ_STAT   9'h14E
`define PSC_ADDR_IRQ_MASK   9'h14F

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PSC_BIT_ON          0
`define PSC_BIT_CLEAR       1
`define PSC_BIT_POLY        2
`define PSC_BIT_RESV_LO     3
`define PSC_BIT_RESV_HI     4
`define PSC_BIT_RSVD5       5
`define PSC_BIT_REAL_MATCH  6
`define PSC_BIT_IMAG_MATCH  7
`define PSC_CTRL_RESV_RST   2'h1

// ----------------------------------------------------------------
// interrupt status and mask fields
// ----------------------------------------------------------------
`define PSC_IRQ_W           4
`define PSC_IRQ_REAL_ERR    0
`define PSC_IRQ_IMAG_ERR    1
`define PSC_IRQ_REAL_SAT    2
`define PSC_IRQ_IMAG_SAT    3

// ----------------------------------------------------------------
// sequence taps, history bit index of each tap (newest bit is 0)
// ----------------------------------------------------------------
`define PSC_TAP15_A         14
`define PSC_TAP15_B         13
`define PSC_TAP7_A          6
`define PSC_TAP7_B          5
`define PSC_HIST_W          15

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define PSC_DATA_W          8
`define PSC_BYTE_ZERO       8'h00
`define PSC_CNT_MAX         8'hFF
`define PSC_LOCK_RUN        4'h8

`endif

// [rtl/psc_pattern_check_ctrl_check.v]
// one channel: self-synchronising sequence comparison of sample words
`default_nettype none
`include "psc_map.vh"

module psc_pattern_check_ctrl_check #(
   parameter SAMPLE_W = 16
) (
   // clock and reset
   input  wire                i_mclk,
   input  wire                i_rst,
   // control
   input  wire                i_enable,
   input  wire                i_poly,
   // sample stream
   input  wire                i_valid,
   input  wire [SAMPLE_W-1:0] i_data,
   // result
   output reg                 o_checked,
   output reg                 o_mismatch
);

   // ----------------------------------------------------------------
   // expected bits from history, msb of the word is the oldest bit
   // ----------------------------------------------------------------
   reg [`PSC_HIST_W-1:0] hist;
   reg [`PSC_HIST_W-1:0] next_hist;
   reg                   next_err;
   reg                   primed;
   reg                   exp_bit;
   integer               k;

   always @* begin
      next_hist = hist;
      next_err  = 1'b0;
      exp_bit   = 1'b0;
      for (k = SAMPLE_W - 1; k >= 0; k = k - 1) begin
         if (i_poly) begin
            exp_bit = next_hist[`PSC_TAP15_A] ^ next_hist[`PSC_TAP15_B];
         end else begin
            exp_bit = next_hist[`PSC_TAP7_A] ^ next_hist[`PSC_TAP7_B];
         end
         if (exp_bit != i_data[k]) begin
            next_err = 1'b1;
         end
         // history follows the received bits so the check relocks itself
         next_hist = {next_hist[`PSC_HIST_W-2:0], i_data[k]};
      end
   end

   // ----------------------------------------------------------------
   // first word after enable only fills the history
   // ----------------------------------------------------------------
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         hist       <= {`PSC_HIST_W{1'b0}};
         primed     <= 1'b0;
         o_checked  <= 1'b0;
         o_mismatch <= 1'b0;
      end else begin
         o_checked  <= 1'b0;
         o_mismatch <= 1'b0;
         if (!i_enable) begin
            primed <= 1'b0;
         end else if (i_valid) begin
            hist       <= next_hist;
            primed     <= 1'b1;
            o_checked  <= primed;
            o_mismatch <= primed & next_err;
         end
      end
   end

endmodule // psc_pattern_check_ctrl_check
`default_nettype wire

// [rtl/psc_sat_count.v]
// saturating error counter with synchronous clear
`default_nettype none
`include "psc_map.vh"

module psc_sat_count #(
   parameter CNT_W = 8
) (
   // clock and reset
   input  wire             i_mclk,
   input  wire             i_rst,
   // control
   input  wire             i_clear,
   input  wire             i_inc,
   // count
   output reg  [CNT_W-1:0] o_count,
   output wire             o_at_max
);

   assign o_at_max = &o_count;

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_count <= {CNT_W{1'b0}};
      end else if (i_clear) begin
         o_count <= {CNT_W{1'b0}};
      end else if (i_inc && !o_at_max) begin
         // sticks at full scale so a long bad run is never hidden
         o_count <= o_count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

endmodule // psc_sat_count
`default_nettype wire

// [rtl/psc_top.v]
// sequence checker top: register port, two channels, interrupt
//
// Summary of operation
// - imaginary match flag, read-only control bit 7, resets 0, 1 on good sequence.
// - real match flag, read-only control bit 6, 0 on bad, 1 on good.
// - control bit 2 set selects the x^15+x^14+1 sequence; resets to 0.
// - real error count at 0x14C, resets 0, held clear while bit 1 set.
// - imaginary error count at 0x14D counts only while control bit 0 set.
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
`include "psc_map.vh"

module psc_top #(
   parameter SAMPLE_W = 16,
   parameter CNT_W    = 8,
   parameter LOCK_RUN = 8
) (
   // clock and reset
   input  wire                    i_mclk,
   input  wire                    i_rst,
   // register port
   input  wire [`PSC_ADDR_W-1:0]  i_addr,
   input  wire [`PSC_DATA_W-1:0]  i_wdata,
   input  wire                    i_wr,
   input  wire                    i_rd,
   output reg  [`PSC_DATA_W-1:0]  o_rdata,
   // received sample path
   input  wire                    i_sample_valid,
   input  wire [SAMPLE_W-1:0]     i_real_data,
   input  wire [SAMPLE_W-1:0]     i_imag_data,
   // status
   output wire                    o_real_match_flag,
   output wire                    o_imag_match_flag,
   output wire                    o_irq
);

   // ----------------------------------------------------------------
   // channel indices
   // ----------------------------------------------------------------
   localparam CH_REAL = 0;
   localparam CH_IMAG = 1;
   localparam N_CH    = 2;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   reg       checker_on;
   reg       counter_clear;
   reg       poly_select;
   reg [1:0] ctrl_resv;

   wire wr_ctrl = i_wr && (i_addr == `PSC_ADDR_CTRL);
   wire wr_stat = i_wr && (i_addr == `PSC_ADDR_IRQ_STAT);
   wire wr_mask = i_wr && (i_addr == `PSC_ADDR_IRQ_MASK);

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         checker_on    <= 1'b0;
         counter_clear <= 1'b0;
         poly_select   <= 1'b0;
         ctrl_resv     <= `PSC_CTRL_RESV_RST;
      end else if (wr_ctrl) begin
         checker_on    <= i_wdata[`PSC_BIT_ON];
         counter_clear <= i_wdata[`PSC_BIT_CLEAR];
         poly_select   <= i_wdata[`PSC_BIT_POLY];
         ctrl_resv     <= i_wdata[`PSC_BIT_RESV_HI:`PSC_BIT_RESV_LO];
      end
   end

   // ----------------------------------------------------------------
   // input sample register
   // ----------------------------------------------------------------
   // one stage keeps the long compare chain off the receive path
   wire [SAMPLE_W-1:0] ch_in [0:N_CH-1];
   reg                 sample_valid_q;

   assign ch_in[CH_REAL] = i_real_data;
   assign ch_in[CH_IMAG] = i_imag_data;

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sample_valid_q <= 1'b0;
      end else begin
         sample_valid_q <= i_sample_valid;
      end
   end

   // ----------------------------------------------------------------
   // match flag states, one-hot
   // ----------------------------------------------------------------
   // the flag is a state bit, so pin and readback come from a flop
   localparam [2:0] ST_IDLE     = 3'b001;
   localparam [2:0] ST_HUNT     = 3'b010;
   localparam [2:0] ST_LOCK     = 3'b100;
   localparam       ST_LOCK_BIT = 2;
   localparam [3:0] LOCK_LAST   = LOCK_RUN[3:0] - 4'h1;

   // ----------------------------------------------------------------
   // per channel checker, error tally and match flag
   // ----------------------------------------------------------------
   wire [N_CH-1:0]  ch_checked;
   wire [N_CH-1:0]  ch_mismatch;
   wire [N_CH-1:0]  ch_at_max;
   wire [N_CH-1:0]  ch_sat_rise;
   wire [N_CH-1:0]  match_flag;
   wire [CNT_W-1:0] real_error_tally;
   wire [CNT_W-1:0] imag_error_tally;
   wire [CNT_W-1:0] tally [0:N_CH-1];

   genvar g;
   generate
      for (g = 0; g < N_CH; g = g + 1) begin : g_ch
         reg [SAMPLE_W-1:0] sample_q;
         reg [2:0]          state;
         reg [2:0]          next_state;
         reg [3:0]          good_run;
         reg [3:0]          next_good_run;
         reg                at_max_q;

         always @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               sample_q <= {SAMPLE_W{1'b0}};
            end else if (i_sample_valid) begin
               sample_q <= ch_in[g];
            end
         end

         psc_pattern_check_ctrl_check #(
            .SAMPLE_W (SAMPLE_W)
         ) u_check (
            .i_mclk     (i_mclk),
            .i_rst      (i_rst),
            .i_enable   (checker_on),
            .i_poly     (poly_select),
            .i_valid    (sample_valid_q),
            .i_data     (sample_q),
            .o_checked  (ch_checked[g]),
            .o_mismatch (ch_mismatch[g])
         );

         psc_sat_count #(
            .CNT_W (CNT_W)
         ) u_count (
            .i_mclk   (i_mclk),
            .i_rst    (i_rst),
            .i_clear  (counter_clear),
            .i_inc    (checker_on & ch_mismatch[g]),
            .o_count  (tally[g]),
            .o_at_max (ch_at_max[g])
         );

         // a run of good words raises the flag, one bad word drops it
         always @* begin
            next_state    = state;
            next_good_run = good_run;
            case (state)
               ST_IDLE: begin
                  // a re-enable always starts a fresh run of good words
                  next_good_run = 4'h0;
                  if (checker_on) begin
                     next_state = ST_HUNT;
                  end
               end
               ST_HUNT: begin
                  if (!checker_on) begin
                     next_state    = ST_IDLE;
                     next_good_run = 4'h0;
                  end else if (ch_mismatch[g]) begin
                     next_good_run = 4'h0;
                  end else if (ch_checked[g]) begin
                     if (good_run == LOCK_LAST) begin
                        next_state = ST_LOCK;
                     end else begin
                        next_good_run = good_run + 4'h1;
                     end
                  end
               end
               ST_LOCK: begin
                  if (!checker_on) begin
                     next_state    = ST_IDLE;
                     next_good_run = 4'h0;
                  end else if (ch_mismatch[g]) begin
                     next_state    = ST_HUNT;
                     next_good_run = 4'h0;
                  end
               end
               default: begin
                  next_state    = ST_IDLE;
                  next_good_run = 4'h0;
               end
            endcase
         end

         always @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               state    <= ST_IDLE;
               good_run <= 4'h0;
               at_max_q <= 1'b0;
            end else begin
               state    <= next_state;
               good_run <= next_good_run;
               at_max_q <= ch_at_max[g];
            end
         end

         assign match_flag[g]  = state[ST_LOCK_BIT];
         assign ch_sat_rise[g] = ch_at_max[g] & ~at_max_q;
      end
   endgenerate

   assign real_error_tally  = tally[CH_REAL];
   assign imag_error_tally  = tally[CH_IMAG];
   assign o_real_match_flag = match_flag[CH_REAL];
   assign o_imag_match_flag = match_flag[CH_IMAG];

   // ----------------------------------------------------------------
   // interrupt status and mask
   // ----------------------------------------------------------------
   reg  [`PSC_IRQ_W-1:0] irq_stat;
   reg  [`PSC_IRQ_W-1:0] irq_mask;
   wire [`PSC_IRQ_W-1:0] irq_set;

   assign irq_set[`PSC_IRQ_REAL_ERR] = ch_mismatch[CH_REAL];
   assign irq_set[`PSC_IRQ_IMAG_ERR] = ch_mismatch[CH_IMAG];
   assign irq_set[`PSC_IRQ_REAL_SAT] = ch_sat_rise[CH_REAL];
   assign irq_set[`PSC_IRQ_IMAG_SAT] = ch_sat_rise[CH_IMAG];

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat <= {`PSC_IRQ_W{1'b0}};
         irq_mask <= {`PSC_IRQ_W{1'b0}};
      end else begin
         // a new event in the clearing cycle survives the clear
         if (wr_stat) begin
            irq_stat <= (irq_stat & ~i_wdata[`PSC_IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         if (wr_mask) begin
            irq_mask <= i_wdata[`PSC_IRQ_W-1:0];
         end
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   reg [`PSC_DATA_W-1:0] rd_mux;

   always @* begin
      rd_mux = `PSC_BYTE_ZERO;
      case (i_addr)
         `PSC_ADDR_CTRL: begin
            rd_mux[`PSC_BIT_IMAG_MATCH] = match_flag[CH_IMAG];
            rd_mux[`PSC_BIT_REAL_MATCH] = match_flag[CH_REAL];
            rd_mux[`PSC_BIT_RESV_HI:`PSC_BIT_RESV_LO] = ctrl_resv;
            rd_mux[`PSC_BIT_POLY]  = poly_select;
            rd_mux[`PSC_BIT_CLEAR] = counter_clear;
            rd_mux[`PSC_BIT_ON]    = checker_on;
         end
         `PSC_ADDR_REAL_CNT: begin
            rd_mux = real_error_tally;
         end
         `PSC_ADDR_IMAG_CNT: begin
            rd_mux = imag_error_tally;
         end
         `PSC_ADDR_IRQ_STAT: begin
            rd_mux[`PSC_IRQ_W-1:0] = irq_stat;
         end
         `PSC_ADDR_IRQ_MASK: begin
            rd_mux[`PSC_IRQ_W-1:0] = irq_mask;
         end
         default: begin
            rd_mux = `PSC_BYTE_ZERO;
         end
      endcase
   end

   // data only in the cycle after the strobe, zero otherwise
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= `PSC_BYTE_ZERO;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end else begin
         o_rdata <= `PSC_BYTE_ZERO;
      end
   end

endmodule // psc_top
`default_nettype wire

// [tb/psc_check_sva.sv]
// port-level assertions for the sequence checker top
`default_nettype none
`include "psc_map.vh"
module psc_check_sva #(
   parameter SAMPLE_W = 16,
   parameter CNT_W    = 8,
   parameter LOCK_RUN = 8
) (
   input wire logic                   i_mclk,
   input wire logic                   i_rst,
   input wire logic [`PSC_ADDR_W-1:0] i_addr,
   input wire logic [`PSC_DATA_W-1:0] i_wdata,
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire logic [`PSC_DATA_W-1:0] o_rdata,
   input wire logic                   i_sample_valid,
   input wire logic [SAMPLE_W-1:0]    i_real_data,
   input wire logic [SAMPLE_W-1:0]    i_imag_data,
   input wire logic                   o_real_match_flag,
   input wire logic                   o_imag_match_flag,
   input wire logic                   o_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // shadow of the writable control bits and mask, seen from the bus
   logic [4:0] ctrl;
   logic [3:0] mask;
   logic [1:0] clr_age;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl    <= 5'h08;
         mask    <= 4'h0;
         clr_age <= 2'h0;
      end else begin
         if (i_wr && i_addr == `PSC_ADDR_CTRL)
            ctrl <= i_wdata[4:0];
         if (i_wr && i_addr == `PSC_ADDR_IRQ_MASK)
            mask <= i_wdata[3:0];
         if (!ctrl[1])
            clr_age <= 2'h0;
         else if (clr_age != 2'h3)
            clr_age <= clr_age + 2'h1;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   rdata_idle_a:
      assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read");
   ctrl_read_a:
      assert property ($past(i_rd && i_addr == `PSC_ADDR_CTRL) |->
         o_rdata == {$past(o_imag_match_flag), $past(o_real_match_flag),
                     1'h0, $past(ctrl)})
      else $error("control readback wrong");
   flag_off_a:
      assert property (!ctrl[0] && !$past(ctrl[0]) && !$past(ctrl[0], 2)
         |-> !o_real_match_flag && !o_imag_match_flag)
      else $error("match flag set while checker off");
   flag_rise_a:
      assert property ($rose(o_real_match_flag) || $rose(o_imag_match_flag)
         |-> $past(ctrl[0]))
      else $error("match flag rose while checker off");
   clear_hold_a:
      assert property ($past(i_rd && clr_age == 2'h3 &&
         (i_addr == `PSC_ADDR_REAL_CNT || i_addr == `PSC_ADDR_IMAG_CNT))
         |-> o_rdata == 8'h00)
      else $error("count not held at zero by clear");
   irq_mask_a:
      assert property (mask == 4'h0 |-> !o_irq)
      else $error("interrupt with all sources masked");
   irq_hold_a:
      assert property (o_irq && !i_wr |=> o_irq)
      else $error("interrupt dropped without a write");
   mask_read_a:
      assert property ($past(i_rd && i_addr == `PSC_ADDR_IRQ_MASK) |->
         o_rdata == {4'h0, $past(mask)})
      else $error("mask readback wrong");
endmodule // psc_check_sva
bind psc_top psc_check_sva #(
   .SAMPLE_W(SAMPLE_W), .CNT_W(CNT_W), .LOCK_RUN(LOCK_RUN)
) chk_u (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_sample_valid(i_sample_valid), .i_real_data(i_real_data),
   .i_imag_data(i_imag_data), .o_real_match_flag(o_real_match_flag),
   .o_imag_match_flag(o_imag_match_flag), .o_irq(o_irq)
);
`default_nettype wire

// [tb/psc_link_model.sv]
// link transmitter model sending sequence sample words
`default_nettype none
module psc_link_model (
   input  wire logic        i_mclk,
   input  wire logic        i_poly,
   output var  logic        o_valid,
   output var  logic [15:0] o_re_word,
   output var  logic [15:0] o_im_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [14:0] hist_re = 15'h1ACE;
   logic [14:0] hist_im = 15'h2B35;
   initial begin
      o_valid   = 1'h0;
      o_re_word = 16'h0000;
      o_im_word = 16'h0000;
   end
   // next 16 bits, oldest first; history keeps the true bits only
   function automatic logic [30:0] step(input logic [14:0] h,
                                        input logic p);
      logic [15:0] w;
      logic        b;
      for (int k = 15; k >= 0; k--) begin
         b = p ? h[14] ^ h[13] : h[6] ^ h[5];
         h = {h[13:0], b};
         w[k] = b;
      end
      return {h, w};
   endfunction
   // flipping the oldest bit spoils exactly one word at the receiver
   task automatic send(input int n, input logic er, input logic ei);
      logic [30:0] sr;
      logic [30:0] si;
      for (int k = 0; k < n; k++) begin
         @(posedge i_mclk);
         sr = step(hist_re, i_poly);
         si = step(hist_im, i_poly);
         hist_re = sr[30:16];
         hist_im = si[30:16];
         o_valid   <= 1'h1;
         o_re_word <= sr[15:0] ^ {er, 15'h0};
         o_im_word <= si[15:0] ^ {ei, 15'h0};
      end
      @(posedge i_mclk);
      o_valid   <= 1'h0;
      o_re_word <= ~o_re_word;
      o_im_word <= ~o_im_word;
   endtask
endmodule // psc_link_model
`default_nettype wire

// [tb/psc_tb.sv]
// self-checking bench for the sequence checker top
`default_nettype none
`include "psc_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOCK = 8;
   logic        i_mclk  = 1'h0;
   logic        i_rst   = 1'h1;
   logic [8:0]  i_addr  = 9'h000;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr    = 1'h0;
   logic        i_rd    = 1'h0;
   logic        poly    = 1'h0;
   logic [7:0]  o_rdata;
   logic        sv;
   logic [15:0] re_w;
   logic [15:0] im_w;
   logic        rflag;
   logic        iflag;
   logic        irq;
   int          fails    = 0;
   int          compares = 0;
   int          cycles   = 0;
   always #10 i_mclk = ~i_mclk;
   psc_link_model link_u (.i_mclk(i_mclk), .i_poly(poly), .o_valid(sv),
      .o_re_word(re_w), .o_im_word(im_w));
   psc_top #(.LOCK_RUN(LOCK)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_sample_valid(sv), .i_real_data(re_w),
      .i_imag_data(im_w), .o_real_match_flag(rflag),
      .o_imag_match_flag(iflag), .o_irq(irq));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'h1;
      @(posedge i_mclk);
      i_wr    <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd   <= 1'h1;
      @(posedge i_mclk);
      i_rd   <= 1'h0;
      #1;
      check(o_rdata, exp);
   endtask
   task automatic idle;
      repeat (4) @(posedge i_mclk);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(`PSC_ADDR_CTRL, 8'h08);
      rd(`PSC_ADDR_REAL_CNT, 8'h00);
      rd(`PSC_ADDR_IMAG_CNT, 8'h00);
      rd(9'h150, 8'h00);
      check({5'h00, irq, iflag, rflag}, 8'h00);
   endtask
   task automatic t_lock;
      logic [7:0] c;
      for (int m = 0; m < 2; m++) begin
         poly = m[0];
         c = {5'h01, m[0], 2'h1};
         wr(`PSC_ADDR_CTRL, 8'h08);
         wr(`PSC_ADDR_CTRL, c);
         link_u.send(LOCK, 1'h0, 1'h0);
         idle;
         rd(`PSC_ADDR_CTRL, c);
         link_u.send(1, 1'h0, 1'h0);
         idle;
         rd(`PSC_ADDR_CTRL, c | 8'hC0);
         check({6'h00, iflag, rflag}, 8'h03);
         rd(`PSC_ADDR_REAL_CNT, 8'h00);
      end
   endtask
   task automatic t_error;
      link_u.send(1, 1'h1, 1'h0);
      link_u.send(2, 1'h0, 1'h0);
      idle;
      rd(`PSC_ADDR_REAL_CNT, 8'h01);
      rd(`PSC_ADDR_IMAG_CNT, 8'h00);
      rd(`PSC_ADDR_CTRL, 8'h8D);
      check({6'h00, iflag, rflag}, 8'h02);
      rd(`PSC_ADDR_IRQ_STAT, 8'h01);
      wr(`PSC_ADDR_IRQ_MASK, 8'h01);
      check({7'h00, irq}, 8'h01);
      wr(`PSC_ADDR_IRQ_STAT, 8'h01);
      check({7'h00, irq}, 8'h00);
   endtask
   task automatic t_clear;
      wr(`PSC_ADDR_CTRL, 8'h0F);
      rd(`PSC_ADDR_REAL_CNT, 8'h00);
      rd(`PSC_ADDR_IMAG_CNT, 8'h00);
      link_u.send(1, 1'h1, 1'h0);
      idle;
      rd(`PSC_ADDR_REAL_CNT, 8'h00);
      wr(`PSC_ADDR_CTRL, 8'h0D);
      link_u.send(1, 1'h1, 1'h0);
      idle;
      rd(`PSC_ADDR_REAL_CNT, 8'h01);
      wr(`PSC_ADDR_IRQ_STAT, 8'h01);
   endtask
   task automatic t_off;
      wr(`PSC_ADDR_CTRL, 8'h0C);
      link_u.send(3, 1'h0, 1'h1);
      idle;
      rd(`PSC_ADDR_IMAG_CNT, 8'h00);
      rd(`PSC_ADDR_CTRL, 8'h0C);
      rd(`PSC_ADDR_IRQ_STAT, 8'h00);
   endtask
   // 260 bad words after priming overrun the 8-bit count
   task automatic t_sat;
      wr(`PSC_ADDR_CTRL, 8'h0D);
      link_u.send(1, 1'h0, 1'h0);
      link_u.send(260, 1'h0, 1'h1);
      idle;
      rd(`PSC_ADDR_IMAG_CNT, 8'hFF);
      wr(`PSC_ADDR_IMAG_CNT, 8'h00);
      rd(`PSC_ADDR_IMAG_CNT, 8'hFF);
      rd(`PSC_ADDR_IRQ_STAT, 8'h0A);
      check({7'h00, irq}, 8'h00);
      wr(`PSC_ADDR_IRQ_MASK, 8'h08);
      check({7'h00, irq}, 8'h01);
      wr(`PSC_ADDR_IRQ_STAT, 8'h0A);
      check({7'h00, irq}, 8'h00);
      wr(`PSC_ADDR_CTRL, 8'h0F);
      rd(`PSC_ADDR_IMAG_CNT, 8'h00);
   endtask
   task automatic stop_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'h0;
      t_reset;
      t_lock;
      t_error;
      t_clear;
      t_off;
      t_sat;
      stop_test;
   end
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test;
      end
   end
endmodule // testbench
`default_nettype wire
